// *** design/exc_entry_map.vh ***
// constants for the exception entry block: vectors, register offsets and bit positions
`ifndef EXC_ENTRY_MAP_VH
`define EXC_ENTRY_MAP_VH

// ----------------------------------------------------------------
// vector offsets
// ----------------------------------------------------------------
`define VEC_RESERVED0     32'h00000000
`define VEC_RESET         32'h00000100
`define VEC_MCHECK        32'h00000200
`define VEC_DSTORAGE      32'h00000300
`define VEC_ISTORAGE      32'h00000400
`define VEC_ALIGN         32'h00000600
`define VEC_PROGRAM       32'h00000700
`define VEC_DECR          32'h00000900
`define VEC_RESERVED_A    32'h00000A00
`define VEC_RESERVED_B    32'h00000B00
`define VEC_SYSCALL       32'h00000C00
`define VEC_TRACE         32'h00000D00
`define VEC_EMUL          32'h00001000
`define VEC_ITLB_MISS     32'h00001100
`define VEC_DTLB_MISS     32'h00001200
`define VEC_ITLB_ERR      32'h00001300
`define VEC_DTLB_ERR      32'h00001400
`define VEC_RSVD_LO       32'h00001500
`define VEC_RSVD_HI       32'h00001BFF
`define VEC_BASE_LOW      32'h00000000
`define VEC_BASE_HIGH     32'hFFF00000

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define REG_SAVED_PC      8'h00
`define REG_SAVED_MSW     8'h04
`define REG_FAULT_CAUSE   8'h08
`define REG_FAULT_ADDR    8'h0C
`define REG_MSW           8'h10
`define REG_CTRL          8'h14
`define REG_STATUS        8'h18

// ----------------------------------------------------------------
// machine state word bit indices (bit 31 here is bit 0 in big-endian numbering)
// ----------------------------------------------------------------
`define MSW_INT_BYTE_ORDER 16
`define MSW_USER_MODE      14
`define MSW_FLOAT_AVAIL    13
`define MSW_CHECK_ENABLE   12
`define MSW_SINGLE_STEP    10
`define MSW_BRANCH_TRACE   9
`define MSW_VEC_BASE_SEL   6
`define MSW_FETCH_XLATE    5
`define MSW_RECOVERABLE    1
`define MSW_BYTE_ORDER     0
`define MSW_RESET          32'h00000000
`define MSW_LOW_HALF       15:0
`define SMS_FETCH_ERR      30
`define HALF_ZERO          16'h0000

// ----------------------------------------------------------------
// fault cause fields, opcode slices in little-endian index form
// ----------------------------------------------------------------
`define OP_X_1516          2:1
`define OP_X_17            6
`define OP_D_17            26
`define OP_X_1821          10:7
`define OP_D_1821          30:27
`define OP_2231            25:16
`define FC_HIGH_ZERO       15'h0000
`define FC_D_1516          2'h0

// ----------------------------------------------------------------
// control and status fields
// ----------------------------------------------------------------
`define CTRL_ALIGN_CHECK   0
`define CTRL_DEBUG_ENABLE  1
`define CTRL_DEBUG_EXIT    2
`define CTRL_RESET         2'h0
`define CAUSE_NONE         4'h0
`define CAUSE_RESET        4'h1
`define CAUSE_MCHECK       4'h2
`define CAUSE_ALIGN        4'h3
`define CAUSE_PROGRAM      4'h4
`define CAUSE_DECR         4'h5
`define CAUSE_SYSCALL      4'h6
`define CAUSE_TRACE        4'h7
`define CAUSE_EMUL         4'h8
`define CAUSE_ITLB_MISS    4'h9
`define ZERO32             32'h00000000

`endif

// *** design/align_check.v ***
// operand alignment classification of a load/store effective address
`timescale 1ns/1ps
`default_nettype none
module align_check (
  input  wire [2:0] ea_low,
  input  wire [1:0] size_code,
  output wire       word_misaligned,
  output wire       natural_misaligned
);
  // ----------------------------------------------------------------
  // size codes: 0 byte, 1 half, 2 word, 3 double
  // ----------------------------------------------------------------
  assign word_misaligned    = (ea_low[1:0] != 2'h0);
  assign natural_misaligned = (size_code == 2'h1) ? ea_low[0] :
                              (size_code == 2'h2) ? (ea_low[1:0] != 2'h0) :
                              (size_code == 2'h3) ? (ea_low != 3'h0) : 1'b0;
endmodule
`default_nettype wire

// *** design/vector_addr.v ***
// handler start address from vector base select and offset
`timescale 1ns/1ps
`include "exc_entry_map.vh"
`default_nettype none
module vector_addr #(
  parameter [31:0] LOW_BASE  = `VEC_BASE_LOW,
  parameter [31:0] HIGH_BASE = `VEC_BASE_HIGH
) (
  input  wire        base_select,
  input  wire [31:0] offset,
  output wire [31:0] addr
);
  // ----------------------------------------------------------------
  // offsets stay below the base granule, so or-ing equals adding
  // ----------------------------------------------------------------
  assign addr = (base_select ? HIGH_BASE : LOW_BASE) + offset;
endmodule
`default_nettype wire

// *** design/core_exception_entry.v ***
// exception entry: vector choice, saved state, fault registers, checkstop and debug entry
`timescale 1ns/1ps
`include "exc_entry_map.vh"
`default_nettype none
module core_exception_entry (
  input  wire        clk,
  input  wire        sys_rst,
  // register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // reset request pin, asynchronous
  input  wire        reset_request_pin,
  input  wire [31:0] next_pc,
  // machine check indication from the internal bus
  input  wire        mchk_valid,
  input  wire        mchk_fetch,
  input  wire [31:0] mchk_instr_addr,
  input  wire [31:0] mchk_opcode,
  input  wire        mchk_xform,
  input  wire [31:0] mchk_data_ea,
  // completing instruction
  input  wire        instr_valid,
  input  wire [31:0] instr_addr,
  input  wire [31:0] instr_next_addr,
  input  wire        instr_is_rfi,
  input  wire        instr_is_branch,
  input  wire        instr_privileged,
  input  wire        instr_unimpl,
  input  wire        instr_is_float,
  input  wire        instr_syscall,
  input  wire        spr_move,
  input  wire        spr_on_core_valid,
  input  wire        spr_on_core_unimpl,
  input  wire        spr_off_core,
  input  wire        spr_off_core_unimpl,
  input  wire        ext_reg_select_bit,
  input  wire        ldst_valid,
  input  wire        ldst_float,
  input  wire        ldst_multiple,
  input  wire        ldst_reserved,
  input  wire        ldst_string,
  input  wire [2:0]  ldst_ea_low,
  input  wire [1:0]  ldst_size,
  // other sources
  input  wire        decr_request,
  input  wire        fetch_miss,
  input  wire [31:0] fetch_miss_addr,
  // results
  output reg         redirect_valid,
  output reg  [31:0] redirect_addr,
  output reg  [31:0] machine_state_word,
  output reg         checkstop,
  output reg         auto_reset_req,
  output reg         debug_entry,
  output reg         debug_state
);
  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  localparam [2:0] ST_RUN       = 3'b001;
  localparam [2:0] ST_CHECKSTOP = 3'b010;
  localparam [2:0] ST_DEBUG     = 3'b100;

  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [31:0] saved_program_counter_q;
  reg  [31:0] saved_machine_state_q;
  reg  [31:0] fault_cause_q;
  reg  [31:0] fault_data_address_q;
  reg  [1:0]  ctrl_q;
  reg  [3:0]  last_cause_q;
  reg         rreq_s1_q;
  reg         rreq_s2_q;
  reg         rreq_s3_q;
  reg         rreq_lvl_q;

  wire        word_mis;
  wire        nat_mis;
  wire [31:0] vec_addr;
  wire        rreq_lvl_d;
  wire        rreq_rise;
  wire        user_mode;
  wire        mchk_en;

  // ----------------------------------------------------------------
  // reset request pin synchroniser; the level moves only once flops two and three agree
  // ----------------------------------------------------------------
  assign rreq_lvl_d = (rreq_s2_q == rreq_s3_q) ? rreq_s3_q : rreq_lvl_q;
  assign rreq_rise  = rreq_lvl_d & ~rreq_lvl_q;

  always @(posedge clk) begin
    if (sys_rst) begin
      rreq_s1_q  <= 1'b0;
      rreq_s2_q  <= 1'b0;
      rreq_s3_q  <= 1'b0;
      rreq_lvl_q <= 1'b0;
    end else begin
      rreq_s1_q  <= reset_request_pin;
      rreq_s2_q  <= rreq_s1_q;
      rreq_s3_q  <= rreq_s2_q;
      rreq_lvl_q <= rreq_lvl_d;
    end
  end

  assign user_mode = machine_state_word[`MSW_USER_MODE];
  assign mchk_en   = machine_state_word[`MSW_CHECK_ENABLE];

  align_check u_align (
    .ea_low             (ldst_ea_low),
    .size_code          (ldst_size),
    .word_misaligned    (word_mis),
    .natural_misaligned (nat_mis)
  );

  // ----------------------------------------------------------------
  // event classification
  // ----------------------------------------------------------------
  wire ev_align = ldst_valid & (((ldst_float | ldst_multiple | ldst_reserved) & word_mis) |
                  (ctrl_q[`CTRL_ALIGN_CHECK] & nat_mis) |
                  ((ldst_multiple | ldst_string) & machine_state_word[`MSW_BYTE_ORDER]));
  // float instructions are routed to emulation regardless of float_available
  wire ev_emul = instr_valid & (instr_unimpl | instr_is_float |
                 (spr_move & spr_on_core_unimpl) |
                 (spr_move & spr_off_core_unimpl & (~ext_reg_select_bit | ~user_mode)));
  // no float-enabled or illegal-opcode program type is ever produced
  wire ev_prog = instr_valid & user_mode & (instr_privileged |
                 (spr_move & spr_on_core_valid) |
                 (spr_move & spr_off_core & ext_reg_select_bit));
  wire ev_itlb = fetch_miss & machine_state_word[`MSW_FETCH_XLATE];
  wire ev_sc   = instr_valid & instr_syscall;
  wire instr_faulted = ev_align | ev_emul | ev_prog | ev_sc;
  // an instruction that raised its own interrupt is never traced
  wire ev_trace = instr_valid & ~instr_faulted &
                  ((machine_state_word[`MSW_SINGLE_STEP] & ~instr_is_rfi) |
                   (machine_state_word[`MSW_BRANCH_TRACE] & instr_is_branch));

  // ----------------------------------------------------------------
  // entry selection
  // ----------------------------------------------------------------
  reg        take;
  reg [3:0]  cause;
  reg [31:0] offset;
  reg [31:0] spc_val;
  reg        sms_fetch;
  reg        fault_load;

  always @* begin
    take       = 1'b0;
    cause      = `CAUSE_NONE;
    offset     = `VEC_RESET;
    spc_val    = next_pc;
    sms_fetch  = 1'b0;
    fault_load = 1'b0;
    state_d    = state_q;
    // storage interrupt vectors are never produced here; software branches to them
    case (state_q)
      ST_RUN: begin
        if (rreq_rise) begin
          take    = 1'b1;
          cause   = `CAUSE_RESET;
          offset  = `VEC_RESET;
          spc_val = next_pc;
        end else if (mchk_valid & mchk_en) begin
          take       = 1'b1;
          cause      = `CAUSE_MCHECK;
          offset     = `VEC_MCHECK;
          spc_val    = mchk_instr_addr;
          sms_fetch  = mchk_fetch;
          fault_load = ~mchk_fetch;
        end else if (mchk_valid) begin
          state_d = ctrl_q[`CTRL_DEBUG_ENABLE] ? ST_DEBUG : ST_CHECKSTOP;
        end else if (ev_itlb) begin
          take    = 1'b1;
          cause   = `CAUSE_ITLB_MISS;
          offset  = `VEC_ITLB_MISS;
          spc_val = fetch_miss_addr;
        end else if (ev_emul) begin
          take    = 1'b1;
          cause   = `CAUSE_EMUL;
          offset  = `VEC_EMUL;
          spc_val = instr_addr;
        end else if (ev_prog) begin
          take    = 1'b1;
          cause   = `CAUSE_PROGRAM;
          offset  = `VEC_PROGRAM;
          spc_val = instr_addr;
        end else if (ev_align) begin
          take    = 1'b1;
          cause   = `CAUSE_ALIGN;
          offset  = `VEC_ALIGN;
          spc_val = instr_addr;
        end else if (ev_sc) begin
          take    = 1'b1;
          cause   = `CAUSE_SYSCALL;
          offset  = `VEC_SYSCALL;
          spc_val = instr_next_addr;
        end else if (decr_request) begin
          take    = 1'b1;
          cause   = `CAUSE_DECR;
          offset  = `VEC_DECR;
          spc_val = next_pc;
        end else if (ev_trace) begin
          take    = 1'b1;
          cause   = `CAUSE_TRACE;
          offset  = `VEC_TRACE;
          spc_val = instr_next_addr;
        end
      end
      ST_CHECKSTOP: begin
        // only a core reset leaves checkstop
        state_d = ST_CHECKSTOP;
      end
      ST_DEBUG: begin
        if (reg_wr && reg_addr == `REG_CTRL && reg_wdata[`CTRL_DEBUG_EXIT]) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  vector_addr u_vec (
    .base_select (machine_state_word[`MSW_VEC_BASE_SEL]),
    .offset      (offset),
    .addr        (vec_addr)
  );

  // ----------------------------------------------------------------
  // values written on entry
  // ----------------------------------------------------------------
  // low half copies the word; bit 30 is set only by a machine check on an instruction fetch
  wire [31:0] sms_entry = {1'b0, sms_fetch, 14'h0000, machine_state_word[`MSW_LOW_HALF]};
  reg  [31:0] msw_entry;
  always @* begin
    msw_entry = `MSW_RESET;
    msw_entry[`MSW_VEC_BASE_SEL] = machine_state_word[`MSW_VEC_BASE_SEL];
    msw_entry[`MSW_CHECK_ENABLE] = (cause == `CAUSE_MCHECK) ? 1'b0 :
                                   machine_state_word[`MSW_CHECK_ENABLE];
    msw_entry[`MSW_BYTE_ORDER]   = machine_state_word[`MSW_INT_BYTE_ORDER];
  end

  wire [31:0] fc_entry = {`FC_HIGH_ZERO,
                          mchk_xform ? mchk_opcode[`OP_X_1516] : `FC_D_1516,
                          mchk_xform ? mchk_opcode[`OP_X_17] : mchk_opcode[`OP_D_17],
                          mchk_xform ? mchk_opcode[`OP_X_1821] : mchk_opcode[`OP_D_1821],
                          mchk_opcode[`OP_2231]};

  wire wr_spc  = reg_wr && (reg_addr == `REG_SAVED_PC);
  wire wr_sms  = reg_wr && (reg_addr == `REG_SAVED_MSW);
  wire wr_fc   = reg_wr && (reg_addr == `REG_FAULT_CAUSE);
  wire wr_fda  = reg_wr && (reg_addr == `REG_FAULT_ADDR);
  wire wr_msw  = reg_wr && (reg_addr == `REG_MSW);
  wire wr_ctrl = reg_wr && (reg_addr == `REG_CTRL);

  // ----------------------------------------------------------------
  // architectural registers; a hardware entry wins over a software write in the same cycle
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      saved_program_counter_q <= `ZERO32;
      saved_machine_state_q   <= `ZERO32;
      fault_cause_q           <= `ZERO32;
      fault_data_address_q    <= `ZERO32;
      machine_state_word      <= `MSW_RESET;
      ctrl_q                  <= `CTRL_RESET;
      last_cause_q            <= `CAUSE_NONE;
    end else begin
      if (take) begin
        saved_program_counter_q <= spc_val;
        saved_machine_state_q   <= sms_entry;
        machine_state_word      <= msw_entry;
        last_cause_q            <= cause;
      end else begin
        if (wr_spc) begin
          saved_program_counter_q <= reg_wdata;
        end
        if (wr_sms) begin
          saved_machine_state_q <= reg_wdata;
        end
        if (wr_msw) begin
          machine_state_word <= reg_wdata;
        end
      end
      if (take & fault_load) begin
        fault_cause_q        <= fc_entry;
        fault_data_address_q <= mchk_data_ea;
      end else begin
        if (wr_fc) begin
          fault_cause_q <= reg_wdata;
        end
        if (wr_fda) begin
          fault_data_address_q <= reg_wdata;
        end
      end
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // control state and result outputs
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      state_q        <= ST_RUN;
      redirect_valid <= 1'b0;
      redirect_addr  <= `ZERO32;
      checkstop      <= 1'b0;
      auto_reset_req <= 1'b0;
      debug_entry    <= 1'b0;
      debug_state    <= 1'b0;
    end else begin
      state_q        <= state_d;
      redirect_valid <= take;
      if (take) begin
        redirect_addr <= vec_addr;
      end
      checkstop      <= (state_d == ST_CHECKSTOP);
      auto_reset_req <= (state_d == ST_CHECKSTOP);
      debug_entry    <= (state_q == ST_RUN) && (state_d == ST_DEBUG);
      debug_state    <= (state_d == ST_DEBUG);
    end
  end

  // ----------------------------------------------------------------
  // register read port; data stand one cycle after the strobe, zero otherwise
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= `ZERO32;
    end else if (reg_rd) begin
      case (reg_addr)
        `REG_SAVED_PC:    reg_rdata <= saved_program_counter_q;
        `REG_SAVED_MSW:   reg_rdata <= saved_machine_state_q;
        `REG_FAULT_CAUSE: reg_rdata <= fault_cause_q;
        `REG_FAULT_ADDR:  reg_rdata <= fault_data_address_q;
        `REG_MSW:         reg_rdata <= machine_state_word;
        `REG_CTRL:        reg_rdata <= {30'h0, ctrl_q};
        `REG_STATUS:      reg_rdata <= {25'h0, last_cause_q, state_q};
        default:          reg_rdata <= `ZERO32;
      endcase
    end else begin
      reg_rdata <= `ZERO32;
    end
  end
endmodule
`default_nettype wire

// *** testbench/core_exception_entry_checker.sv ***
// port assertions for the exception entry block
`timescale 1ns/1ps
`default_nettype none
module core_exception_entry_checker (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        reset_request_pin,
  input wire logic        mchk_valid,
  input wire logic        redirect_valid,
  input wire logic [31:0] redirect_addr,
  input wire logic [31:0] machine_state_word,
  input wire logic        checkstop,
  input wire logic        auto_reset_req,
  input wire logic        debug_entry,
  input wire logic        debug_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // entry checks
  // ----------------------------------------------------------------
  // pin excluded: its synchronised rise outranks the check
  wire run_ok = !checkstop && !debug_state && !reset_request_pin;
  wire mc_on  = mchk_valid && machine_state_word[12] && run_ok;
  wire mc_off = mchk_valid && !machine_state_word[12] && run_ok;
  a_check_vector: assert property (
    mc_on |=> redirect_valid && redirect_addr[15:0] == 16'h0200) else $error("bad check vector");
  a_check_enable_off: assert property (
    mc_on |=> !machine_state_word[12]) else $error("check enable kept");
  a_stop_or_debug: assert property (
    mc_off |=> (checkstop ^ debug_entry) && !redirect_valid) else $error("no stop or debug");
  a_stop_reset_req: assert property (
    checkstop == auto_reset_req) else $error("reset indication mismatch");
  a_stop_holds: assert property (
    checkstop |=> checkstop && !redirect_valid) else $error("checkstop left");
  a_debug_level: assert property (
    debug_entry |-> debug_state && !checkstop) else $error("debug pulse alone");
  a_base_select: assert property (
    redirect_valid |-> redirect_addr[31:13] == (machine_state_word[6] ? 19'h7FF80 : 19'h0))
    else $error("bad vector base");
  a_entry_state: assert property (
    redirect_valid |-> (machine_state_word & 32'hFFFFEFBE) == 32'h0
      && machine_state_word[0] == $past(machine_state_word[16])) else $error("bad entry state");
  a_no_reserved: assert property (
    redirect_valid |-> !(redirect_addr[15:0] inside {16'h0000, 16'h0300, 16'h0400, 16'h0A00, 16'h0B00}))
    else $error("reserved vector used");
  c_check_taken: cover property (mc_on);
  c_stop: cover property (mc_off ##1 checkstop);
  c_debug: cover property ($rose(debug_state));
  c_high_base: cover property (redirect_valid && machine_state_word[6]);
endmodule
bind core_exception_entry core_exception_entry_checker u_core_exception_entry_checker (.*);
`default_nettype wire

// *** testbench/bus_check_model.sv ***
// internal bus model: raises machine-check indications with their qualifiers
`timescale 1ns/1ps
`default_nettype none
module bus_check_model (
  input  wire logic        clk,
  output logic             mchk_valid,
  output logic             mchk_fetch,
  output logic [31:0]      mchk_instr_addr,
  output logic [31:0]      mchk_opcode,
  output logic             mchk_xform,
  output logic [31:0]      mchk_data_ea
);
  initial {mchk_valid, mchk_fetch, mchk_xform, mchk_instr_addr, mchk_opcode, mchk_data_ea} = 99'h0;
  // ----------------------------------------------------------------
  // one-cycle fault answer to an address or data phase
  // ----------------------------------------------------------------
  task automatic raise(input f, input x, input [31:0] pc, input [31:0] op, input [31:0] ea);
    begin
      @(posedge clk);
      mchk_valid <= 1'b1;
      {mchk_fetch, mchk_xform, mchk_instr_addr, mchk_opcode, mchk_data_ea} <= {f, x, pc, op, ea};
      @(posedge clk);
      mchk_valid <= 1'b0;
      // address, opcode and data address are inverted after the phase so a late sample fails; fetch and xform are kept
      {mchk_instr_addr, mchk_opcode, mchk_data_ea} <= ~{pc, op, ea};
    end
  endtask
endmodule
`default_nettype wire

// *** testbench/core_exception_entry_tb_top.sv ***
// self-checking bench for the exception entry block
`timescale 1ns/1ps
`include "exc_entry_map.vh"
`default_nettype none
module core_exception_entry_tb_top;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, reset_request_pin = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, next_pc = 32'h0, instr_addr = 32'h0;
  logic [31:0] instr_next_addr = 32'h0, fetch_miss_addr = 32'h0;
  logic [19:0] flg = 20'h0;
  logic [2:0]  ldst_ea_low = 3'h0;
  logic [1:0]  ldst_size = 2'h0;
  wire  [31:0] reg_rdata, redirect_addr, machine_state_word, mchk_instr_addr, mchk_opcode, mchk_data_ea;
  wire         redirect_valid, checkstop, auto_reset_req, debug_entry, debug_state;
  wire         mchk_valid, mchk_fetch, mchk_xform, instr_valid, instr_is_rfi, instr_is_branch, instr_privileged;
  wire         instr_unimpl, instr_is_float, instr_syscall, spr_move, spr_on_core_valid, spr_on_core_unimpl;
  wire         spr_off_core, spr_off_core_unimpl, ext_reg_select_bit, ldst_valid, ldst_float, ldst_multiple;
  wire         ldst_reserved, ldst_string, decr_request, fetch_miss;
  int          fail_count = 0;
  int          samples_checked = 0;
  assign {instr_valid, instr_is_rfi, instr_is_branch, instr_privileged, instr_unimpl, instr_is_float,
          instr_syscall, spr_move, spr_on_core_valid, spr_on_core_unimpl, spr_off_core, spr_off_core_unimpl,
          ext_reg_select_bit, ldst_valid, ldst_float, ldst_multiple, ldst_reserved, ldst_string,
          decr_request, fetch_miss} = flg;
  always #12.5 clk = ~clk;
  core_exception_entry u_core_exception_entry (.*);
  bus_check_model u_bus_check_model (.*);
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic check(input [31:0] got, input [31:0] exp);
    begin
      samples_checked++;
      if (got !== exp) begin
        fail_count++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  task automatic rd(input [7:0] a, input [31:0] exp);
    begin
      @(posedge clk);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      check(reg_rdata, exp);
    end
  endtask
  task automatic do_reset;
    begin
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
    end
  endtask
  task automatic fire(input [19:0] f, input [4:0] es, input [31:0] pc);
    begin
      @(posedge clk);
      {flg, ldst_ea_low, ldst_size, instr_addr} <= {f, es, pc};
      {instr_next_addr, fetch_miss_addr} <= {pc + 32'h4, pc + 32'h8};
      @(posedge clk);
      flg <= 20'h0;
    end
  endtask
  // sel: 0 own pc, 1 next pc, 2 missed fetch, 3 unchecked
  task automatic rc(input [19:0] f, input [31:0] m, input [5:0] es, input [15:0] off, input [1:0] sel);
    logic [31:0] pc;
    begin
      pc = 32'h4000 + {16'h0, off};
      wr(`REG_MSW, m);
      wr(`REG_CTRL, {31'h0, es[5]});
      fire(f, es[4:0], pc);
      @(negedge clk);
      check(redirect_valid, off != 16'h0000);
      if (off != 16'h0000) begin
        check(redirect_addr, {m[6] ? 16'hFFF0 : 16'h0000, off});
        check(machine_state_word, (m & 32'h1040) | {31'h0, m[16]});
        rd(`REG_SAVED_MSW, {16'h0, m[15:0]});
        if (sel != 2'h3) rd(`REG_SAVED_PC, pc + {28'h0, sel, 2'h0});
      end
    end
  endtask
  task automatic mck(input f, input x, input [31:0] m, input [31:0] op);
    begin
      wr(`REG_MSW, m);
      u_bus_check_model.raise(f, x, 32'h5550, op, 32'h12345678);
      @(negedge clk);
      check(redirect_addr, {m[6] ? 16'hFFF0 : 16'h0000, 16'h0200});
      check(machine_state_word, (m & 32'h40) | {31'h0, m[16]});
      rd(`REG_SAVED_PC, 32'h5550);
      rd(`REG_SAVED_MSW, {1'b0, f, 14'h0, m[15:0]});
      if (!f) rd(`REG_FAULT_CAUSE, {15'h0, x ? op[2:1] : 2'h0, x ? op[6] : op[26],
                                    x ? op[10:7] : op[30:27], op[25:16]});
      if (!f) rd(`REG_FAULT_ADDR, 32'h12345678);
    end
  endtask
  task automatic print_verdict;
    begin
      if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    rd(`REG_MSW, 32'h0);
    rd(8'hFC, 32'h0);
    rc(20'h88000, 32'h10000, 6'h0, 16'h1000, 2'h0);
    rc(20'h84000, 32'h2040, 6'h0, 16'h1000, 2'h0);
    rc(20'h81400, 32'h4000, 6'h0, 16'h1000, 2'h0);
    rc(20'h81300, 32'h4000, 6'h0, 16'h1000, 2'h0);
    rc(20'h90000, 32'h4000, 6'h0, 16'h0700, 2'h3);
    rc(20'h81280, 32'h4040, 6'h0, 16'h0700, 2'h3);
    rc(20'h81800, 32'h4000, 6'h0, 16'h0700, 2'h3);
    rc(20'h90000, 32'h0, 6'h0, 16'h0, 2'h3);
    rc(20'h00060, 32'h0, 6'h0A, 16'h0600, 2'h3);
    rc(20'h00050, 32'h10000, 6'h06, 16'h0600, 2'h3);
    rc(20'h00048, 32'h0, 6'h0E, 16'h0600, 2'h3);
    rc(20'h00040, 32'h0, 6'h25, 16'h0600, 2'h3);
    rc(20'h00040, 32'h0, 6'h05, 16'h0, 2'h3);
    rc(20'h00044, 32'h1, 6'h02, 16'h0600, 2'h3);
    rc(20'h82000, 32'h40, 6'h0, 16'h0C00, 2'h3);
    rc(20'h00002, 32'h0, 6'h0, 16'h0900, 2'h3);
    rc(20'h80000, 32'h402, 6'h0, 16'h0D00, 2'h1);
    rc(20'hA0000, 32'h200, 6'h0, 16'h0D00, 2'h1);
    rc(20'hC0000, 32'h400, 6'h0, 16'h0, 2'h3);
    rc(20'h88000, 32'h400, 6'h0, 16'h1000, 2'h0);
    rc(20'h00001, 32'h20, 6'h0, 16'h1100, 2'h2);
    rc(20'h00001, 32'h0, 6'h0, 16'h0, 2'h3);
    rc(20'h88001, 32'h20, 6'h0, 16'h1100, 2'h2);
    rc(20'h8A000, 32'h0, 6'h0, 16'h1000, 2'h0);
    mck(1'b0, 1'b1, 32'h11043, 32'h7C8A4D2E);
    mck(1'b0, 1'b0, 32'h1000, 32'hA5C3F00F);
    mck(1'b1, 1'b0, 32'h1002, 32'h0);
    wr(`REG_MSW, 32'h1000);
    fork
      u_bus_check_model.raise(1'b1, 1'b0, 32'h5550, 32'h0, 32'h0);
      fire(20'h82000, 5'h0, 32'h6000);
    join
    @(negedge clk);
    check(redirect_addr, 32'h200);
    wr(`REG_MSW, 32'h10040);
    @(posedge clk);
    {reset_request_pin, next_pc} <= {1'b1, 32'h7770};
    repeat (10) begin
      @(negedge clk);
      if (redirect_valid === 1'b1) break;
    end
    check(redirect_addr, 32'hFFF00100);
    check(machine_state_word, 32'h41);
    rd(`REG_SAVED_PC, 32'h7770);
    @(posedge clk);
    reset_request_pin <= 1'b0;
    wr(`REG_MSW, 32'h0);
    u_bus_check_model.raise(1'b0, 1'b1, 32'h5550, 32'h0, 32'h0);
    @(negedge clk);
    check({checkstop, auto_reset_req, debug_state}, 3'h6);
    fire(20'h82000, 5'h0, 32'h6000);
    @(negedge clk);
    check(redirect_valid, 1'b0);
    do_reset();
    wr(`REG_CTRL, 32'h2);
    u_bus_check_model.raise(1'b0, 1'b1, 32'h5550, 32'h0, 32'h0);
    @(negedge clk);
    check({debug_entry, debug_state, checkstop}, 3'h6);
    wr(`REG_CTRL, 32'h4);
    rc(20'h82000, 32'h0, 6'h0, 16'h0C00, 2'h3);
    print_verdict();
  end
endmodule
`default_nettype wire
